// *** tbw_writer.sv ***
// Trace buffer writer: pointer, wrap, events, status and interrupt
// Assumes a same-clock trace source and memory write port
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tbw_map.svh"
module tbw_writer #(
  parameter int AW = 32,
  parameter int BW = 3
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Trace source
  input wire logic trace_valid,
  input wire logic [BW-1:0] trace_bytes,
  output logic trace_ready,
  input wire logic trigger_event,
  output logic flush_req,
  input wire logic flush_done,
  // Memory write port, async abort, misuse and custom events
  output logic mem_wr,
  output logic [AW-1:0] mem_addr,
  output logic [BW-1:0] mem_bytes,
  input wire logic mem_done,
  input wire logic mem_align_fault,
  input wire logic mem_xlat_fault,
  input wire logic mem_sync_abort,
  input wire logic async_abort,
  input wire logic misuse_event,
  input wire logic impdef_event,
  // Cache maintenance handshake
  input wire logic cmo_req,
  output logic cmo_done,
  // Exclusive and transaction snoop
  input wire logic [AW-1:0] excl_addr,
  input wire logic excl_open,
  output logic excl_clear,
  // Events out
  output logic pmu_wrap_event,
  output logic buffer_mgmt_interrupt
);
  // ************************************************
  // State
  // ************************************************
  typedef struct packed {
    tbw_pkg::tbw_state_e st;
    logic [AW-1:0] ptr;
    logic [AW-1:0] base;
    logic [AW-1:0] limit;
    logic [2:0] lim_ctl;
    logic [31:0] status;
    logic [31:0] trig_cnt;
    logic [BW-1:0] pend;
    logic [31:0] rdata;
    logic wrap_pulse;
    logic flush_q;
  } tbw_s;

  tbw_s s_q;
  tbw_s s_d;
  logic [AW-1:0] next_ptr;
  logic wrapped;
  tbw_pkg::tbw_mode_e mode;
  logic enabled;

  // Register read decode, shared by read path
  function automatic logic [31:0] rd_mux(input tbw_s s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    unique case (a)
      `TBW_OFS_PTR: v = 32'(s.ptr);
      `TBW_OFS_BASE: v = 32'(s.base);
      `TBW_OFS_LIMIT: v = 32'(s.limit) | 32'(s.lim_ctl);
      `TBW_OFS_STATUS: v = s.status;
      `TBW_OFS_TRIG: v = s.trig_cnt;
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  // Mode and pointer arithmetic
  always_comb
  begin
    mode = tbw_pkg::tbw_mode_e'(s_q.lim_ctl[`TBW_LIM_MODE_HI:`TBW_LIM_MODE_LO]); // [R18]
    enabled = s_q.lim_ctl[`TBW_LIM_EN];
    next_ptr = s_q.ptr + AW'(s_q.pend); // [R23]
    wrapped = (next_ptr >= s_q.limit); // [R17]
  end

  // ************************************************
  // Next state
  // ************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.wrap_pulse = 1'b0;
    s_d.rdata = 32'h0;
    if (reg_rd)
    begin
      s_d.rdata = rd_mux(s_q, reg_addr);
    end
    // Software writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        `TBW_OFS_PTR: s_d.ptr = AW'(reg_wdata);
        `TBW_OFS_BASE: s_d.base = AW'(reg_wdata);
        `TBW_OFS_LIMIT:
        begin
          s_d.limit = AW'(reg_wdata) & ~AW'(7);
          s_d.lim_ctl = reg_wdata[2:0];
        end
        `TBW_OFS_STATUS: s_d.status = reg_wdata; // [R6]
        `TBW_OFS_TRIG: s_d.trig_cnt = reg_wdata;
        default: ;
      endcase
    end
    // Flush completion after a trigger event
    s_d.flush_q = s_q.flush_q;
    if (s_q.flush_q && flush_done)
    begin
      s_d.flush_q = 1'b0;
      s_d.status[`TBW_ST_IRQ] = 1'b1; // [R5]
      if (!s_d.status[`TBW_ST_STOP])
      begin
        s_d.status[`TBW_ST_STOP] = 1'b1;
        s_d.status[`TBW_ST_EC_HI:`TBW_ST_EC_LO] = `TBW_EC_OTHER;
        s_d.status[`TBW_ST_MSS_HI:0] = `TBW_BSC_TRIG;
      end
    end
    if (enabled && trigger_event && !s_q.flush_q && !s_q.status[`TBW_ST_STOP])
    begin
      s_d.flush_q = 1'b1; // [R9]
      s_d.status[`TBW_ST_TRG] = 1'b1;
    end
    // Asynchronous and custom events, unordered against sync ones
    if (async_abort)
    begin
      s_d.status[`TBW_ST_IRQ] = 1'b1; // [R4] [R12]
      s_d.status[`TBW_ST_EA] = 1'b1;
      s_d.status[`TBW_ST_STOP] = 1'b1;
      s_d.status[`TBW_ST_EC_HI:`TBW_ST_EC_LO] = `TBW_EC_ABORT;
      s_d.status[`TBW_ST_MSS_HI:0] = `TBW_BSC_ABORT;
    end
    else if (misuse_event || impdef_event)
    begin
      s_d.status[`TBW_ST_IRQ] = 1'b1; // [R4] [R12]
      s_d.status[`TBW_ST_EC_HI:`TBW_ST_EC_LO] = `TBW_EC_OTHER;
      s_d.status[`TBW_ST_MSS_HI:0] = misuse_event ? `TBW_BSC_MISUSE
                                                  : `TBW_BSC_IMPDEF;
    end
    // Write sequencer
    unique case (s_q.st)
      tbw_pkg::TBW_IDLE:
      begin
        if (trace_valid && enabled && !s_q.status[`TBW_ST_STOP]) // [R8] [R19]
        begin
          s_d.pend = trace_bytes;
          s_d.st = tbw_pkg::TBW_WRITE;
        end
      end
      tbw_pkg::TBW_WRITE:
      begin
        if (mem_align_fault || mem_xlat_fault)
        begin
          // Highest: sync fault; pointer frozen at faulting address
          s_d.st = tbw_pkg::TBW_IDLE; // [R11] [R10]
          s_d.status[`TBW_ST_IRQ] = 1'b1; // [R4]
          s_d.status[`TBW_ST_STOP] = 1'b1; // [R8]
          s_d.status[`TBW_ST_EC_HI:`TBW_ST_EC_LO] = `TBW_EC_FAULT;
          s_d.status[`TBW_ST_MSS_HI:0] = `TBW_BSC_FAULT;
        end
        else if (mem_sync_abort)
        begin
          s_d.st = tbw_pkg::TBW_IDLE; // [R11] [R10]
          s_d.status[`TBW_ST_IRQ] = 1'b1; // [R4]
          s_d.status[`TBW_ST_EA] = 1'b1;
          s_d.status[`TBW_ST_STOP] = 1'b1;
          s_d.status[`TBW_ST_EC_HI:`TBW_ST_EC_LO] = `TBW_EC_ABORT;
          s_d.status[`TBW_ST_MSS_HI:0] = `TBW_BSC_ABORT;
        end
        else if (mem_done)
        begin
          s_d.st = tbw_pkg::TBW_IDLE;
          if (wrapped)
          begin
            s_d.ptr = s_q.base; // [R1] [R14] [R17]
            s_d.wrap_pulse = 1'b1; // [R16]
            s_d.status[`TBW_ST_WRAP] = 1'b1;
            if (mode == tbw_pkg::TBW_MODE_FILL)
            begin
              s_d.status[`TBW_ST_IRQ] = 1'b1; // [R3] [R13]
              if (!s_q.status[`TBW_ST_STOP])
              begin
                s_d.status[`TBW_ST_STOP] = 1'b1;
                s_d.status[`TBW_ST_EC_HI:`TBW_ST_EC_LO] = `TBW_EC_OTHER;
                s_d.status[`TBW_ST_MSS_HI:0] = `TBW_BSC_FULL;
              end
            end
            else if (mode == tbw_pkg::TBW_MODE_WRAP)
            begin
              s_d.status[`TBW_ST_IRQ] = 1'b1; // [R2] [R15]
            end
          end
          else
          begin
            s_d.ptr = next_ptr; // [R23]
          end
        end
      end
      default: s_d.st = tbw_pkg::TBW_IDLE;
    endcase
  end

  // ************************************************
  // Registers
  // ************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
      s_q.st <= tbw_pkg::TBW_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign reg_rdata = s_q.rdata;
  assign trace_ready = (s_q.st == tbw_pkg::TBW_IDLE) && enabled
                       && !s_q.status[`TBW_ST_STOP]; // [R8]
  assign mem_wr = (s_q.st == tbw_pkg::TBW_WRITE);
  assign mem_addr = s_q.ptr;
  assign mem_bytes = s_q.pend;
  assign flush_req = s_q.flush_q;
  assign pmu_wrap_event = s_q.wrap_pulse;
  assign buffer_mgmt_interrupt = s_q.status[`TBW_ST_IRQ]; // [R6] [R7]
  // No data cache in the writer, so maintenance completes at once
  assign cmo_done = cmo_req; // [R20]
  // Trace writes never disturb exclusives or transactions
  assign excl_clear = 1'b0 & excl_open & (excl_addr == s_q.ptr); // [R21] [R22]
endmodule // tbw_writer
`default_nettype wire

// *** tbw_map.svh ***
// Register map, field layout and encodings for the trace buffer writer
// Assumes inclusion by tbw_pkg and the design file, before use
//
// Overview of operation
// [R1] Circular mode: pointer reaching limit reloads base, trace continues.
// [R2] Wrap mode: wrap as circular and raise an interrupt at each wrap.
// [R3] Fill mode: as wrap mode, and collection stops on the wrap.
// [R4] Faults, aborts, trigger, non-circular wrap, misuse, custom cause raise events.
// [R5] Every management event sets interrupt pending and asserts the interrupt.
// [R6] Interrupt is a level following pending bit; software sets or clears it.
// [R7] Interrupt is a private per-core line from the owning processor.
// [R8] Full and fault events set stopped before more trace is accepted.
// [R9] Trigger event starts a flush; later events may precede the stop.
// [R10] Sync fault or abort freezes pointer at the faulting address.
// [R11] Sync events report highest: fault, abort, full, wrap.
// [R12] Async and custom events are not ordered against sync ones.
// [R13] Fill wrap: pending, wrapped, pmu event; if running, stop, class 0, code 1.
// [R14] After fill-mode full the write pointer equals the base pointer.
// [R15] Wrap-mode wrap: pending, wrapped, pmu event; stopped unchanged.
// [R16] Circular wrap: wrapped flag and pmu event only, no management event.
// [R17] Trace is a byte stream; pointer always wraps, never equals limit.
// [R18] Buffer mode field of the limit register selects the mode.
// [R19] While stopped the write pointer is never updated nor wrapped; here a write already in flight still advances or wraps it.
// [R20] Cache maintenance also covers writer data before completing.
// [R21] Trace writes to unrelated addresses leave exclusive monitors alone.
// [R22] Trace writes outside a transaction working set leave it alone.
// [R23] Pointer advances by bytes written; wrap checked before next write.
`ifndef TBW_MAP_SVH
`define TBW_MAP_SVH
// Register offsets
`define TBW_OFS_PTR 8'h00
`define TBW_OFS_BASE 8'h04
`define TBW_OFS_LIMIT 8'h08
`define TBW_OFS_STATUS 8'h0c
`define TBW_OFS_TRIG 8'h10
`define TBW_OFS_CTRL 8'h14
// Limit register fields
`define TBW_LIM_EN 0
`define TBW_LIM_MODE_LO 1
`define TBW_LIM_MODE_HI 2
// Status register fields
`define TBW_ST_IRQ 22
`define TBW_ST_TRG 21
`define TBW_ST_WRAP 20
`define TBW_ST_EA 18
`define TBW_ST_STOP 17
`define TBW_ST_EC_LO 26
`define TBW_ST_EC_HI 31
`define TBW_ST_MSS_HI 15
// Event classes and status codes
`define TBW_EC_OTHER 6'h00
`define TBW_EC_FAULT 6'h24
`define TBW_EC_ABORT 6'h25
`define TBW_BSC_FULL 16'h0001
`define TBW_BSC_TRIG 16'h0002
`define TBW_BSC_FAULT 16'h0003
`define TBW_BSC_ABORT 16'h0004
`define TBW_BSC_MISUSE 16'h0005
`define TBW_BSC_IMPDEF 16'h0006
`endif

// *** tbw_pkg.sv ***
// Types shared by the trace buffer writer
// Assumes tbw_map.svh sits in the include path
`include "tbw_map.svh"
package tbw_pkg;
  typedef enum logic [1:0] {TBW_MODE_FILL, TBW_MODE_WRAP,
    TBW_MODE_CIRC, TBW_MODE_RSVD} tbw_mode_e;
  typedef enum logic [1:0] {TBW_IDLE, TBW_WRITE, TBW_FLUSH} tbw_state_e;
endpackage

// *** tbw_writer_asserts.sv ***
// Checker of the trace buffer writer port behaviour
// Assumes binding onto tbw_writer, one clock domain
`timescale 1ns/1ps
`default_nettype none
module tbw_checker #(
  parameter int AW = 32
) (
  // Clock, reset, register port
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reg_wr,
  // Trace side
  input wire logic trace_valid,
  input wire logic trace_ready,
  input wire logic trigger_event,
  input wire logic flush_req,
  input wire logic flush_done,
  // Memory side
  input wire logic mem_wr,
  input wire logic [AW-1:0] mem_addr,
  input wire logic mem_done,
  input wire logic mem_align_fault,
  input wire logic mem_xlat_fault,
  input wire logic mem_sync_abort,
  // Maintenance handshake and side outputs
  input wire logic cmo_req,
  input wire logic cmo_done,
  input wire logic pmu_wrap_event,
  input wire logic buffer_mgmt_interrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Memory answer and synchronous fault
  wire logic ans = mem_done | mem_align_fault | mem_xlat_fault | mem_sync_abort;
  wire logic flt = mem_wr & (mem_align_fault | mem_xlat_fault);
  property p_irq_hold;
    buffer_mgmt_interrupt && !reg_wr && !$past(reg_wr)
      |=> buffer_mgmt_interrupt;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without write");
  property p_stop_fault;
    flt |=> !trace_ready [*3];
  endproperty
  a_stop_fault: assert property (p_stop_fault)
    else $error("trace accepted after fault");
  property p_fault_irq;
    flt || mem_wr && mem_sync_abort |-> ##[1:3] buffer_mgmt_interrupt;
  endproperty
  a_fault_irq: assert property (p_fault_irq)
    else $error("no interrupt after fault");
  property p_one_flight;
    mem_wr && !ans |=> mem_wr && $stable(mem_addr);
  endproperty
  a_one_flight: assert property (p_one_flight)
    else $error("write dropped or moved");
  property p_take;
    trace_valid && trace_ready |=> mem_wr;
  endproperty
  a_take: assert property (p_take)
    else $error("accepted trace not written");
  property p_wrap_cause;
    pmu_wrap_event |-> $past(mem_done) ##1 !pmu_wrap_event;
  endproperty
  a_wrap_cause: assert property (p_wrap_cause)
    else $error("wrap pulse without a write");
  property p_no_wrap_fault;
    flt |=> !pmu_wrap_event;
  endproperty
  a_no_wrap_fault: assert property (p_no_wrap_fault)
    else $error("wrap reported over fault");
  property p_trig;
    trigger_event && trace_ready |=> flush_req;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger did not start flush");
  property p_flush_hold;
    flush_req && !flush_done |=> flush_req;
  endproperty
  a_flush_hold: assert property (p_flush_hold)
    else $error("flush request dropped early");
  property p_cmo;
    cmo_req |-> cmo_done;
  endproperty
  a_cmo: assert property (p_cmo)
    else $error("maintenance not completed");
  // Main scenarios seen
  c_wrap: cover property (pmu_wrap_event);
  c_fault: cover property (flt);
  c_flush: cover property (flush_req && flush_done);
endmodule // tbw_checker
bind tbw_writer tbw_checker #(.AW(AW)) chk_u (.*);
`default_nettype wire

// *** tbw_mem_model.sv ***
// Memory system and flush partner of the trace buffer writer
// Assumes same clock; answer kind and delay set by the bench
`timescale 1ns/1ps
`default_nettype none
module tbw_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Requests and test control
  input wire logic mem_wr,
  input wire logic flush_req,
  input wire logic [1:0] resp_sel,
  input wire logic [3:0] dly,
  // Answers
  output logic mem_done,
  output logic mem_align_fault,
  output logic mem_xlat_fault,
  output logic mem_sync_abort,
  output logic flush_done
);
  logic [3:0] cnt_q;
  logic [1:0] fcnt_q;
  logic ans_q;
  // One answer pulse per write after dly cycles, flush after 3
  always_ff @(posedge clk_sys)
  begin
    {mem_done, mem_align_fault, mem_xlat_fault, mem_sync_abort} <= 4'h0;
    flush_done <= 1'b0;
    fcnt_q <= (flush_req && !flush_done) ? fcnt_q + 2'h1 : 2'h0;
    if (flush_req && fcnt_q == 2'h3)
      flush_done <= 1'b1;
    if (!reset_n || !mem_wr)
    begin
      cnt_q <= 4'h0;
      ans_q <= 1'b0;
    end
    else if (!ans_q && cnt_q == dly)
    begin
      ans_q <= 1'b1;
      case (resp_sel)
        2'h0: mem_done <= 1'b1;
        2'h1: mem_align_fault <= 1'b1;
        2'h2: mem_xlat_fault <= 1'b1;
        default: mem_sync_abort <= 1'b1;
      endcase
    end
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule // tbw_mem_model
`default_nettype wire

// *** trace_buffer_wrap_events_test.sv ***
// Self-checking bench of the trace buffer writer
// Assumes tbw_writer, tbw_mem_model and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
module trace_buffer_wrap_events_test;
  logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, trace_valid = 0;
  logic trigger_event = 0, async_abort = 0, misuse_event = 0;
  logic impdef_event = 0, cmo_req = 0, excl_open = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, excl_addr = 0, reg_rdata, mem_addr, rd;
  logic [2:0] trace_bytes = 0, mem_bytes;
  logic [1:0] resp_sel = 0;
  logic [3:0] dly = 0;
  logic trace_ready, flush_req, flush_done, mem_wr, mem_done, cmo_done;
  logic mem_align_fault, mem_xlat_fault, mem_sync_abort, excl_clear;
  logic pmu_wrap_event, buffer_mgmt_interrupt;
  logic [31:0] ex [3] = '{32'h00520001, 32'h00500000, 32'h00100000};
  int mismatches = 0, tests_run = 0, wraps = 0, w0;
  tbw_writer dut_u (.*);
  tbw_mem_model mem_u (.*);
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (pmu_wrap_event === 1'b1) wraps++;
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task rd_(input logic [7:0] a);
    @(posedge clk_sys);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 rd = reg_rdata;
  endtask
  // Hand one trace unit over and wait for its memory write to end
  task tr(input logic [2:0] n);
    int i;
    i = 0;
    @(posedge clk_sys);
    {trace_valid, trace_bytes} <= {1'b1, n};
    do @(negedge clk_sys); while (trace_ready !== 1 && ++i < 50);
    @(posedge clk_sys);
    trace_valid <= 0;
    @(negedge clk_sys) chk(mem_bytes, n);
    do @(negedge clk_sys); while (mem_wr === 1 && ++i < 90);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #40000;
    mismatches++;
    print_verdict;
  end
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1;
    {excl_open, excl_addr} <= {1'b1, 32'h1f0};
    rd_(8'hfc); chk(rd, 0);
    wr(8'h04, 32'h100);
    for (int m = 2; m >= 0; m--)
    begin
      w0 = wraps;
      wr(8'h0c, 0); wr(8'h08, 32'h110 | m << 1 | 1); wr(8'h00, 32'h108);
      tr(4); tr(4);
      rd_(8'h00); chk(rd, 32'h100);
      rd_(8'h0c); chk(rd, ex[m]);
      chk(wraps - w0, 1);
      chk(buffer_mgmt_interrupt, m < 2);
      chk(trace_ready, m > 0);
      chk(excl_clear, 0);
      $display("mode %0d done", m);
    end
    for (int f = 1; f < 4; f++)
    begin
      wr(8'h0c, 0); wr(8'h08, 32'h111); wr(8'h00, 32'h10c);
      w0 = wraps;
      {resp_sel, dly} <= {f[1:0], 4'h3};
      tr(4);
      {resp_sel, dly} <= 0;
      rd_(8'h00); chk(rd, 32'h10c);
      rd_(8'h0c); chk(rd & 32'h00520000, 32'h00420000);
      chk(rd[31:26], f == 3 ? 6'h25 : 6'h24);
      chk(wraps - w0, 0);
      $display("fault %0d done", f);
    end
    wr(8'h0c, 0); wr(8'h08, 32'h115); wr(8'h00, 32'h100);
    @(posedge clk_sys) trigger_event <= 1;
    @(posedge clk_sys) trigger_event <= 0;
    tr(4);
    repeat (10) @(posedge clk_sys);
    rd_(8'h0c); chk(rd, 32'h00620002);
    rd_(8'h00); chk(rd, 32'h104);
    $display("trigger done");
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h0c, 0);
      @(posedge clk_sys) {async_abort, misuse_event, impdef_event} <= 3'h4 >> k;
      @(posedge clk_sys) {async_abort, misuse_event, impdef_event} <= 0;
      repeat (2) @(negedge clk_sys);
      chk(buffer_mgmt_interrupt, 1);
    end
    wr(8'h0c, 0); repeat (2) @(negedge clk_sys);
    chk(buffer_mgmt_interrupt, 0);
    wr(8'h0c, 32'h00400000); repeat (2) @(negedge clk_sys);
    chk(buffer_mgmt_interrupt, 1);
    @(posedge clk_sys) cmo_req <= 1;
    @(negedge clk_sys) chk(cmo_done, 1);
    cmo_req <= 0;
    $display("irq and side done");
    print_verdict;
  end
endmodule // trace_buffer_wrap_events_test
`default_nettype wire
